//--- include/hpds_regs.svh
// Constants and rule summary for the host-port data pin select block.
// Contract
// - Data pins go to parallel I/O when boot select low, host bus when high.
// - Pin function is fixed at reset release and kept until next reset.
// - Enabled bus holders keep floating pins at the last driven level.
// - Holders enabled at reset; software may enable or disable them afterwards.
// - In parallel I/O mode all eight bits are inputs after reset.
// - In host mode data lines are inputs until host-port logic requests drive.
// - Boot select high runs the host port multiplexed over eight data lines.
// - Each multiplexed host access is exactly two consecutive byte transfers.
`ifndef HPDS_REGS_SVH
`define HPDS_REGS_SVH
`define HPDS_WIDTH        8
`define HPDS_HOLD_RST     1'b1
`define HPDS_DIR_RST      8'h00
`define HPDS_MODE_RST     1'b0
`endif

//--- include/hpds_pkg.sv
// Types for the host-port data pin select block.
package hpds_pkg;
   typedef enum logic {HPDS_FN_PARIO, HPDS_FN_HOST} hpds_fn_t;
   typedef enum {HPDS_ST_ADDR, HPDS_ST_DATA} hpds_phase_t;
endpackage

//--- design/hpds_sync.sv
// Two-flop synchroniser for pin inputs.
`include "hpds_regs.svh"
module hpds_sync (
   // Clock
   input  wire logic                  clk,
   // Data
   input  wire logic [`HPDS_WIDTH:0]  d,
   output logic      [`HPDS_WIDTH:0]  q
);
   // ---------------------------------------------------------------
   // Synchroniser stages
   // ---------------------------------------------------------------
   // There is no reset here, so the strap level reaches the capture flop while reset is low.
   logic [`HPDS_WIDTH:0] meta_reg;
   always_ff @(posedge clk) begin
      meta_reg <= d;
      q        <= meta_reg;
   end
endmodule

//--- design/hpds_top.sv
// Host-port data pin function select, bus holder and multiplexed byte sequencer.
`include "hpds_regs.svh"
module hpds_top (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // Strap
   input  wire logic        boot_select_pin,
   // Data pins
   input  wire logic [7:0]  host_port_data_pins_in,
   output logic      [7:0]  host_port_data_pins_out,
   output logic      [7:0]  host_port_data_pins_oe,
   // Bus holder control from the external bus control register
   input  wire logic        hold_en_wr,
   input  wire logic        hold_en_val,
   output logic             hold_en,
   // Parallel I/O side
   input  wire logic [7:0]  parallel_io_bits_upper_out,
   input  wire logic [7:0]  parallel_io_bits_upper_dir,
   output logic      [7:0]  parallel_io_bits_upper_in,
   // Host-port logic side
   input  wire logic        host_drive_req,
   input  wire logic [7:0]  host_data_lines_out,
   input  wire logic        host_xfer_strobe,
   output logic      [7:0]  host_data_lines_in,
   output logic             host_byte_valid,
   output logic             host_byte_is_second,
   // Mode
   output logic             host_mode
);
   // ---------------------------------------------------------------
   // Pin synchronisation
   // ---------------------------------------------------------------
   logic [8:0] sync_q;
   hpds_sync u_sync (
      .clk  (clk),
      .d    ({boot_select_pin, host_port_data_pins_in}),
      .q    (sync_q)
   );
   wire       boot_s = sync_q[8];
   wire [7:0] pins_s = sync_q[7:0];

   // ---------------------------------------------------------------
   // Strap capture
   // ---------------------------------------------------------------
   // The strap is sampled on every clock while reset is low and frozen once released.
   hpds_pkg::hpds_fn_t fn_reg;
   logic               strap_reg;
   logic               in_rst_reg;
   always_ff @(posedge clk) begin
      strap_reg  <= nrst ? strap_reg : boot_s;
      in_rst_reg <= !nrst;
   end
   always_ff @(posedge clk) begin
      if (!nrst) begin
         fn_reg <= hpds_pkg::HPDS_FN_PARIO;
      end else if (in_rst_reg) begin
         fn_reg <= strap_reg ? hpds_pkg::HPDS_FN_HOST : hpds_pkg::HPDS_FN_PARIO;
      end
   end
   // host mode means multiplexed operation over the eight lines.
   assign host_mode = (fn_reg == hpds_pkg::HPDS_FN_HOST) && !in_rst_reg;

   // ---------------------------------------------------------------
   // Bus holder enable
   // ---------------------------------------------------------------
   logic hold_reg;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         hold_reg <= `HPDS_HOLD_RST;
      end else if (hold_en_wr) begin
         hold_reg <= hold_en_val;
      end
   end
   assign hold_en = hold_reg;

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------
   // Driven bits take the new value and undriven bits keep the held level.
   function automatic logic [7:0] merge_levels(input logic [7:0] drv,
                                               input logic [7:0] en,
                                               input logic [7:0] held);
      return (drv & en) | (held & ~en);
   endfunction

   // Gates a synchronised pin word to the side that owns the pins.
   function automatic logic [7:0] gate_side(input logic       sel,
                                            input logic [7:0] val);
      return sel ? val : 8'h00;
   endfunction

   // ---------------------------------------------------------------
   // Pin routing
   // ---------------------------------------------------------------
   wire       par_sel = !host_mode;
   wire [7:0] drive_oe = par_sel ? parallel_io_bits_upper_dir
                                 : {8{host_drive_req}};
   wire [7:0] drive_val = par_sel ? parallel_io_bits_upper_out : host_data_lines_out;
   logic [7:0] oe_reg;
   logic [7:0] out_reg;
   logic [7:0] last_reg;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         oe_reg   <= `HPDS_DIR_RST;
         out_reg  <= 8'h00;
         last_reg <= 8'h00;
      end else begin
         oe_reg   <= drive_oe;
         out_reg  <= drive_val;
         if (|oe_reg) begin
            last_reg <= merge_levels(out_reg, oe_reg, last_reg);
         end
      end
   end
   // Holders drive weakly the last level on every pin left undriven.
   wire [7:0] hold_oe = hold_reg ? ~oe_reg : 8'h00;
   assign host_port_data_pins_oe  = oe_reg | hold_oe;
   assign host_port_data_pins_out = merge_levels(out_reg, oe_reg, last_reg);
   // The idle side reads zero so it cannot act on traffic meant for the other function.
   assign parallel_io_bits_upper_in = gate_side(par_sel, pins_s);
   assign host_data_lines_in = gate_side(host_mode, pins_s);

   // ---------------------------------------------------------------
   // Two-byte access sequencer
   // ---------------------------------------------------------------
   hpds_pkg::hpds_phase_t phase_reg;
   hpds_pkg::hpds_phase_t phase_next;
   always_comb begin
      phase_next = phase_reg;
      case (phase_reg)
         hpds_pkg::HPDS_ST_ADDR: begin
            if (host_xfer_strobe && host_mode) begin
               phase_next = hpds_pkg::HPDS_ST_DATA;
            end
         end
         hpds_pkg::HPDS_ST_DATA: begin
            if (host_xfer_strobe) begin
               phase_next = hpds_pkg::HPDS_ST_ADDR;
            end
         end
         default: begin
            phase_next = hpds_pkg::HPDS_ST_ADDR;
         end
      endcase
   end
   always_ff @(posedge clk) begin
      if (!nrst) begin
         phase_reg           <= hpds_pkg::HPDS_ST_ADDR;
         host_byte_valid     <= 1'b0;
         host_byte_is_second <= 1'b0;
      end else begin
         phase_reg           <= phase_next;
         host_byte_valid     <= host_xfer_strobe && host_mode;
         host_byte_is_second <= phase_reg == hpds_pkg::HPDS_ST_DATA;
      end
   end
endmodule

//--- bench/hpds_host_model.sv
// Host processor model: one address byte then one data byte per access.
module hpds_host_model (
   input wire logic       clk, go,
   input wire logic [7:0] a_byte, d_byte, pin_oe, pin_out,
   output logic           xfer,
   output logic [7:0]     pin_lvl
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] ph_reg = 2'h0;
   logic [7:0] last_reg = 8'h00;
   // A released, undriven line shows the inverse of its last level.
   assign xfer = ^ph_reg;
   assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & (xfer ? (ph_reg[1] ? d_byte : a_byte) : ~last_reg));
   always_ff @(posedge clk) begin
      ph_reg <= go ? 2'h1 : ph_reg + {1'b0, ph_reg != 2'h0};
      last_reg <= pin_lvl;
   end
endmodule

//--- bench/hpds_chk.sv
// Concurrent checks on the pin select block ports.
module hpds_chk (
   input wire logic       clk, nrst, hold_en_wr, hold_en_val, hold_en, host_mode,
   input wire logic       host_drive_req, host_xfer_strobe, host_byte_valid, host_byte_is_second,
   input wire logic [7:0] host_port_data_pins_oe, parallel_io_bits_upper_dir
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] up_reg;
   wire s = up_reg == 3'h7 && !hold_en_wr;
   always_ff @(posedge clk) up_reg <= !nrst ? 3'h0 : up_reg + {2'h0, up_reg != 3'h7};
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_mode_fixed: assert property (s |-> $stable(host_mode)) else $error("mode moved");
   a_hold_rst: assert property (disable iff (1'b0)
      !nrst |=> hold_en && host_port_data_pins_oe == 8'hFF) else $error("holder off");
   a_hold_wr: assert property (hold_en_wr |=> hold_en == $past(hold_en_val))
      else $error("holder write lost");
   a_hold_keep: assert property (s && hold_en |=> host_port_data_pins_oe == 8'hFF)
      else $error("holder released pin");
   a_gpio_dir: assert property (s && !host_mode && !hold_en |=>
      host_port_data_pins_oe == $past(parallel_io_bits_upper_dir)) else $error("io dir");
   a_host_drv: assert property (s && host_mode && !hold_en |=>
      host_port_data_pins_oe == {8{$past(host_drive_req)}}) else $error("host drive");
   a_byte_valid: assert property (s && host_xfer_strobe |=>
      host_byte_valid == $past(host_mode)) else $error("byte valid");
   a_byte_pair: assert property (host_byte_valid && host_xfer_strobe |=>
      host_byte_is_second != $past(host_byte_is_second)) else $error("byte order");
   c_pair: cover property (host_byte_valid && host_byte_is_second);
   c_drive: cover property (host_mode && host_drive_req);
   c_hold_off: cover property (hold_en_wr && !hold_en_val);
endmodule
bind hpds_top hpds_chk chk_i (.*);

//--- bench/test_host_port_data_pin_select.sv
// Self-checking testbench for the pin select block.
module test_host_port_data_pin_select;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clk = 0, nrst = 0, boot = 0, hwr = 0, hval = 0, hreq = 0, go = 0;
   logic [7:0] gdir = 8'h00, gout = 8'h00, hout = 8'h00, oe, out, gin, hin, lvl;
   logic       hen, xfer, bv, b2, hm;
   int         fails = 0, n_compared = 0;
   hpds_host_model host (.clk(clk), .go(go), .a_byte(8'h5A), .d_byte(8'hC3), .pin_oe(oe),
      .pin_out(out), .xfer(xfer), .pin_lvl(lvl));
   hpds_top DUT (.clk(clk), .nrst(nrst), .boot_select_pin(boot), .host_port_data_pins_in(lvl),
      .host_port_data_pins_out(out), .host_port_data_pins_oe(oe), .hold_en_wr(hwr),
      .hold_en_val(hval), .hold_en(hen), .parallel_io_bits_upper_out(gout),
      .parallel_io_bits_upper_dir(gdir), .parallel_io_bits_upper_in(gin),
      .host_drive_req(hreq), .host_data_lines_out(hout), .host_xfer_strobe(xfer),
      .host_data_lines_in(hin), .host_byte_valid(bv), .host_byte_is_second(b2), .host_mode(hm));
   initial forever #12.5 clk = ~clk;
   task test_done;
      $display("mismatches %0d of %0d compared", fails, n_compared);
      if (fails == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task chk(input bit ok);
      n_compared++;
      if (!ok) begin
         fails++;
         $display("[FAIL] %0t ns: mismatch", $time);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // The strap flips right after release and must have no effect.
   task start(input logic b);
      nrst <= 0; boot <= b; cyc(4);
      nrst <= 1; cyc(1); boot <= ~b; cyc(3);
   endtask
   task hold(input logic v);
      hwr <= 1; hval <= v; cyc(1);
      hwr <= 0; cyc(2);
   endtask
   task bytes(input logic exp);
      go <= 1; cyc(1); go <= 0;
      for (int i = 0; i < 8 && bv !== 1'b1; i++) cyc(1);
      if (exp && bv !== 1'b1) begin
         fails++;
         test_done;
      end
      chk(bv === exp);
      if (exp) begin
         chk(b2 === 1'b0);
         cyc(1);
         chk(bv === 1'b1 && b2 === 1'b1);
      end
   endtask
   task t_gpio;
      start(1'b0);
      chk(hm === 1'b0 && hen === 1'b1 && oe === 8'hFF);
      hold(1'b0);
      chk(hen === 1'b0 && oe === 8'h00);
      gdir <= 8'h0F; gout <= 8'hA5; cyc(5);
      chk(oe === 8'h0F && out[3:0] === 4'h5 && gin[3:0] === 4'h5 && hin === 8'h00);
      bytes(1'b0);
      hold(1'b1); gdir <= 8'h00; cyc(3);
      chk(oe === 8'hFF && out[3:0] === 4'h5 && hm === 1'b0);
      chk(gin[3:0] === 4'h5);
   endtask
   task t_host;
      start(1'b1);
      chk(hm === 1'b1 && gin === 8'h00);
      hold(1'b0);
      chk(oe === 8'h00);
      bytes(1'b1);
      bytes(1'b1);
      hreq <= 1; hout <= 8'h3C; cyc(5);
      chk(oe === 8'hFF && out === 8'h3C && hin === 8'h3C);
      hreq <= 0; cyc(2);
      chk(oe === 8'h00 && hm === 1'b1);
   endtask
   initial begin
      t_gpio;
      t_host;
      test_done;
   end
endmodule
